// ===== pkg/tbp_pkg.sv
// Constants, types and register map of the teach button and process data
// Contract
// - Button disables after timeout, default 5 min
// - Held over 12 s: abandon, nothing changes
// - Short press: both indicators on steadily
// - Hold 4 s: analog teach, yellow 2 Hz
// - Two short presses store low, high limit
// - Far first point gives inverted characteristic
// - Hold 2 s: zero teach, green 2 Hz
// - Distances reported relative to zero point, signed
// - Hold 8 s: factory reset, both 2 Hz
// - Success: both on briefly, then normal
// - Failure: both indicators blink at 8 Hz
// - Expert or express button behaviour, expert default
// - Output bit 0 switches laser
// - Output bit 1 makes indicators locate unit
// - Input bit 0 is switching channel
// - Input bit 2 set on poor quality
// - Input bit 3 set on alarm
// - Input bits 8..15 hold scale exponent
// - Input bits 16..47 hold measured value
// - Process image exchanged every link cycle
// - Parameters only through acyclic register access
package tbp_pkg;

  // Timing base: one tick of 62.5 ms serves both blink rates
  localparam int CLK_NS        = 20;
  localparam int TICK_US       = 62500;
  localparam int TICK_CYC      = (TICK_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int ZERO_HOLD_MS  = 2000;
  localparam int ANA_HOLD_MS   = 4000;
  localparam int RST_HOLD_MS   = 8000;
  localparam int ABANDON_MS    = 12000;
  localparam int WINDOW_MS     = 60000;
  localparam int DONE_MS       = 1000;
  localparam int FAIL_MS       = 3000;
  localparam int BTN_TIMEOUT_S = 300;
  localparam int TICKS_PER_S   = 1000000 / TICK_US;

  // Least times round up, the confirmation window rounds down
  localparam logic [7:0] ZERO_HOLD_T =
    8'((ZERO_HOLD_MS * 1000 + TICK_US - 1) / TICK_US);
  localparam logic [7:0] ANA_HOLD_T =
    8'((ANA_HOLD_MS * 1000 + TICK_US - 1) / TICK_US);
  localparam logic [7:0] RST_HOLD_T =
    8'((RST_HOLD_MS * 1000 + TICK_US - 1) / TICK_US);
  localparam logic [7:0] ABANDON_T =
    8'((ABANDON_MS * 1000 + TICK_US - 1) / TICK_US);
  localparam logic [9:0] WINDOW_T = 10'(WINDOW_MS * 1000 / TICK_US);
  localparam logic [9:0] DONE_T =
    10'((DONE_MS * 1000 + TICK_US - 1) / TICK_US);
  localparam logic [9:0] FAIL_T =
    10'((FAIL_MS * 1000 + TICK_US - 1) / TICK_US);
  localparam logic [7:0]  PRESS_MAX  = 8'hFF;
  localparam logic [15:0] TIMEOUT_RST = 16'(BTN_TIMEOUT_S);

  // Blink phase bits: bit 0 toggles at 8 Hz, bit 2 at 2 Hz
  localparam int BLINK_FAST = 0;
  localparam int BLINK_SLOW = 2;

  // Register byte offsets
  localparam logic [11:0] REG_CTRL    = 12'h000;
  localparam logic [11:0] REG_TIMEOUT = 12'h004;
  localparam logic [11:0] REG_ZERO    = 12'h008;
  localparam logic [11:0] REG_ANA_LO  = 12'h00C;
  localparam logic [11:0] REG_ANA_HI  = 12'h010;
  localparam logic [11:0] REG_STATUS  = 12'h014;
  localparam int CTRL_EXPRESS = 0;
  localparam int CTRL_REARM   = 1;

  typedef enum logic [3:0] {
    TB_IDLE      = 4'h0,
    TB_ARMED     = 4'h1,
    TB_HOLD      = 4'h3,
    TB_WAIT_LO   = 4'h2,
    TB_WAIT_HI   = 4'h6,
    TB_WAIT_ZERO = 4'h7,
    TB_DONE      = 4'h5,
    TB_FAIL      = 4'h4
  } tbp_state_t;

  // Cyclic output image from the link master
  typedef struct packed {
    logic [5:0] rsvd;
    logic       locate;
    logic       laser_on;
  } tbp_pd_out_t;

  // Cyclic input image to the link master, bit 47 first
  typedef struct packed {
    logic [31:0] value;
    logic [7:0]  scale;
    logic [3:0]  rsvd_hi;
    logic        alarm;
    logic        quality_low;
    logic        rsvd_lo;
    logic        switching_channel_one;
  } tbp_pd_in_t;

endpackage : tbp_pkg

// ===== hw/tbp_teach_pd.sv
// Teach button sequencer, indicator control and process image mapping
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
module tbp_teach_pd
  import tbp_pkg::*;
#(
  parameter int          TICK_CYC_P = TICK_CYC,
  parameter logic [31:0] ZERO_DEF   = 32'h0000_0000,
  parameter logic [31:0] ANA_LO_DEF = 32'h0000_0000,
  parameter logic [31:0] ANA_HI_DEF = 32'h0000_FFFF
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        button_i,
  input  wire logic [31:0] distance_i,
  input  wire logic        switching_channel_one_i,
  input  wire logic        quality_low_i,
  input  wire logic        alarm_i,
  input  wire logic [7:0]  scale_i,
  input  wire logic        pd_strobe_i,
  input  wire tbp_pd_out_t pd_out_i,
  output tbp_pd_in_t       pd_in_o,
  output logic             led_green_o,
  output logic             led_yellow_o,
  output logic             laser_en_o,
  output logic      [31:0] zero_pos_o,
  output logic      [31:0] ana_lo_o,
  output logic      [31:0] ana_hi_o,
  output logic             ana_invert_o
);

  // Prescaler must fit its 22-bit counter
  if (TICK_CYC_P < 1 || TICK_CYC_P > 4194304) begin : g_chk
    $error("TICK_CYC_P out of range");
  end

  tbp_state_t  state;
  tbp_state_t  next_state;
  logic [21:0] pre_cnt;
  logic        tick;
  logic [2:0]  blink_ph;
  logic        btn_s1;
  logic        btn_s2;
  logic        btn_s3;
  logic        btn_lvl;
  logic        btn_prev;
  logic        press_rise;
  logic        press_fall;
  logic [7:0]  press_cnt;
  logic        abandon;
  logic        short_rel;
  logic [9:0]  win_cnt;
  logic        win_over;
  logic [19:0] avail_cnt;
  logic [19:0] avail_lim;
  logic        avail;
  logic        express;
  logic [15:0] btn_timeout;
  logic        laser_on;
  logic        locate;
  logic [31:0] rel_dist;
  logic        st_lo;
  logic        st_hi;
  logic        st_zero;
  logic        factory;
  logic        next_green;
  logic        next_yellow;

  // Prescaler: one tick every 62.5 ms
  assign tick = (pre_cnt == 22'(TICK_CYC_P - 1));

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pre_cnt  <= 22'h000000;
      blink_ph <= 3'h0;
    end else begin
      pre_cnt  <= tick ? 22'h000000 : pre_cnt + 22'h000001;
      blink_ph <= tick ? blink_ph + 3'h1 : blink_ph;
    end
  end

  // Button pin: three stages, level moves when stages two and three agree
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      btn_s1   <= 1'b0;
      btn_s2   <= 1'b0;
      btn_s3   <= 1'b0;
      btn_lvl  <= 1'b0;
      btn_prev <= 1'b0;
    end else begin
      btn_s1   <= button_i;
      btn_s2   <= btn_s1;
      btn_s3   <= btn_s2;
      btn_lvl  <= (btn_s2 == btn_s3) ? btn_s3 : btn_lvl;
      btn_prev <= btn_lvl;
    end
  end

  assign press_rise = btn_lvl & ~btn_prev;
  assign press_fall = ~btn_lvl & btn_prev;

  // Press duration in ticks, saturating so a stuck button cannot wrap
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      press_cnt <= 8'h00;
    end else if (press_rise) begin
      press_cnt <= 8'h00;
    end else if (btn_lvl && tick && press_cnt != PRESS_MAX) begin
      press_cnt <= press_cnt + 8'h01;
    end
  end

  assign abandon   = btn_lvl & (press_cnt > ABANDON_T);
  assign short_rel = press_fall & (press_cnt < ZERO_HOLD_T);

  // Window timer restarts on every state change
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      win_cnt <= 10'h000;
    end else if (next_state != state) begin
      win_cnt <= 10'h000;
    end else if (tick && win_cnt != 10'h3FF) begin
      win_cnt <= win_cnt + 10'h001;
    end
  end

  assign win_over = (win_cnt >= WINDOW_T);

  // Availability: counts from the last accepted press or re-arm; a timeout of
  // zero disables the button at once
  assign avail_lim = 20'(btn_timeout * TICKS_PER_S);
  assign avail     = (avail_cnt < avail_lim);

  wire apb_wr    = psel_i & penable_i & pwrite_i;
  wire wr_ctrl   = apb_wr & (paddr_i == REG_CTRL);
  wire wr_tmo    = apb_wr & (paddr_i == REG_TIMEOUT);
  wire wr_zero   = apb_wr & (paddr_i == REG_ZERO);
  wire wr_lo     = apb_wr & (paddr_i == REG_ANA_LO);
  wire wr_hi     = apb_wr & (paddr_i == REG_ANA_HI);
  wire rearm     = wr_ctrl & pwdata_i[CTRL_REARM];

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      avail_cnt <= 20'h00000;
    end else if ((press_rise && avail) || rearm) begin
      avail_cnt <= 20'h00000;
    end else if (tick && avail) begin
      avail_cnt <= avail_cnt + 20'h00001;
    end
  end

  // Sequencer transitions; holding past 12 s drops back from anywhere
  always_comb begin
    next_state = state;
    unique case (state)
      TB_IDLE: begin
        if (press_rise && avail) begin
          next_state = express ? TB_HOLD : TB_ARMED;
        end
      end
      TB_ARMED: begin
        if (press_rise) begin
          next_state = TB_HOLD;
        end else if (win_over) begin
          next_state = TB_IDLE;
        end
      end
      TB_HOLD: begin
        if (press_fall) begin
          if (press_cnt < ZERO_HOLD_T) begin
            next_state = express ? TB_IDLE : TB_ARMED;
          end else if (press_cnt < ANA_HOLD_T) begin
            next_state = TB_WAIT_ZERO;
          end else if (press_cnt < RST_HOLD_T) begin
            next_state = TB_WAIT_LO;
          end else begin
            next_state = TB_DONE;
          end
        end
      end
      TB_WAIT_LO: begin
        if (short_rel) begin
          next_state = TB_WAIT_HI;
        end else if (press_fall || win_over) begin
          next_state = TB_FAIL;
        end
      end
      TB_WAIT_HI,
      TB_WAIT_ZERO: begin
        if (short_rel) begin
          next_state = TB_DONE;
        end else if (press_fall || win_over) begin
          next_state = TB_FAIL;
        end
      end
      TB_DONE: begin
        if (win_cnt >= DONE_T) begin
          next_state = TB_IDLE;
        end
      end
      TB_FAIL: begin
        if (win_cnt >= FAIL_T) begin
          next_state = TB_IDLE;
        end
      end
      default: begin
        next_state = TB_IDLE;
      end
    endcase
    if (abandon && state != TB_IDLE) begin
      next_state = TB_IDLE;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= TB_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Stores fire only on the confirming release, never after abandon
  assign rel_dist = distance_i - zero_pos_o;
  assign st_lo   = (state == TB_WAIT_LO) & short_rel & ~abandon;
  assign st_hi   = (state == TB_WAIT_HI) & short_rel & ~abandon;
  assign st_zero = (state == TB_WAIT_ZERO) & short_rel & ~abandon;
  assign factory = (state == TB_HOLD) & press_fall
                 & (press_cnt >= RST_HOLD_T) & ~abandon;

  // Parameters: a teach store outranks a bus write in the same cycle
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      zero_pos_o  <= ZERO_DEF;
      ana_lo_o    <= ANA_LO_DEF;
      ana_hi_o    <= ANA_HI_DEF;
      express     <= 1'b0;
      btn_timeout <= TIMEOUT_RST;
    end else if (factory) begin
      zero_pos_o  <= ZERO_DEF;
      ana_lo_o    <= ANA_LO_DEF;
      ana_hi_o    <= ANA_HI_DEF;
      express     <= 1'b0;
      btn_timeout <= TIMEOUT_RST;
    end else begin
      if (st_zero) begin
        zero_pos_o <= distance_i;
      end else if (wr_zero) begin
        zero_pos_o <= pwdata_i;
      end
      if (st_lo) begin
        ana_lo_o <= rel_dist;
      end else if (wr_lo) begin
        ana_lo_o <= pwdata_i;
      end
      if (st_hi) begin
        ana_hi_o <= rel_dist;
      end else if (wr_hi) begin
        ana_hi_o <= pwdata_i;
      end
      if (wr_ctrl) begin
        express <= pwdata_i[CTRL_EXPRESS];
      end
      if (wr_tmo) begin
        btn_timeout <= pwdata_i[15:0];
      end
    end
  end

  // Inverted slope when the first point lies beyond the second
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ana_invert_o <= 1'b0;
    end else begin
      ana_invert_o <= $signed(ana_lo_o) > $signed(ana_hi_o);
    end
  end

  // Indicator pattern per state; locate only while the button is idle
  wire slow = blink_ph[BLINK_SLOW];
  wire fast = blink_ph[BLINK_FAST];

  always_comb begin
    next_green  = 1'b1;
    next_yellow = alarm_i;
    unique case (state)
      TB_IDLE: begin
        if (locate) begin
          next_green  = slow;
          next_yellow = slow;
        end
      end
      TB_ARMED: begin
        next_green  = 1'b1;
        next_yellow = 1'b1;
      end
      TB_HOLD: begin
        if (press_cnt < ZERO_HOLD_T) begin
          next_green  = 1'b1;
          next_yellow = 1'b1;
        end else if (press_cnt < ANA_HOLD_T) begin
          next_green  = slow;
          next_yellow = 1'b0;
        end else if (press_cnt < RST_HOLD_T) begin
          next_green  = 1'b0;
          next_yellow = slow;
        end else begin
          next_green  = slow;
          next_yellow = slow;
        end
      end
      TB_WAIT_LO,
      TB_WAIT_HI: begin
        next_green  = 1'b0;
        next_yellow = slow;
      end
      TB_WAIT_ZERO: begin
        next_green  = slow;
        next_yellow = 1'b0;
      end
      TB_DONE: begin
        next_green  = 1'b1;
        next_yellow = 1'b1;
      end
      TB_FAIL: begin
        next_green  = fast;
        next_yellow = fast;
      end
      default: begin
        next_green  = 1'b0;
        next_yellow = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      led_green_o  <= 1'b0;
      led_yellow_o <= 1'b0;
    end else begin
      led_green_o  <= next_green;
      led_yellow_o <= next_yellow;
    end
  end

  // Cyclic exchange: both images move on each link cycle strobe
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      laser_on <= 1'b0;
      locate   <= 1'b0;
      pd_in_o  <= '0;
    end else if (pd_strobe_i) begin
      laser_on                      <= pd_out_i.laser_on;
      locate                        <= pd_out_i.locate;
      pd_in_o.value                 <= rel_dist;
      pd_in_o.scale                 <= scale_i;
      pd_in_o.rsvd_hi               <= 4'h0;
      pd_in_o.alarm                 <= alarm_i;
      pd_in_o.quality_low           <= quality_low_i;
      pd_in_o.rsvd_lo               <= 1'b0;
      pd_in_o.switching_channel_one <= switching_channel_one_i;
    end
  end

  assign laser_en_o = laser_on;

  // Read decode; data is latched in the setup cycle so it leaves a flop
  wire        setup  = psel_i & ~penable_i;
  wire        hit_ct = (paddr_i == REG_CTRL);
  wire        hit_to = (paddr_i == REG_TIMEOUT);
  wire        hit_zp = (paddr_i == REG_ZERO);
  wire        hit_lo = (paddr_i == REG_ANA_LO);
  wire        hit_hi = (paddr_i == REG_ANA_HI);
  wire        hit_st = (paddr_i == REG_STATUS);
  wire        mapped = hit_ct | hit_to | hit_zp | hit_lo | hit_hi | hit_st;
  wire [31:0] status = {22'h000000, btn_lvl, locate, laser_on,
                        ana_invert_o, avail, express, state};
  wire [31:0] rd_mux = hit_ct ? {31'h00000000, express} :
                       hit_to ? {16'h0000, btn_timeout} :
                       hit_zp ? zero_pos_o :
                       hit_lo ? ana_lo_o :
                       hit_hi ? ana_hi_o :
                       hit_st ? status : 32'h0000_0000;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (setup) begin
      prdata_o  <= pwrite_i ? 32'h0000_0000 : rd_mux;
      pslverr_o <= ~mapped | (pwrite_i & hit_st);
    end
  end

  // No wait states: every access phase completes at once
  assign pready_o = psel_i & penable_i;

endmodule : tbp_teach_pd

// ===== bench/tbp_teach_pd_monitor.sv
// Port checker for the teach button and process image block
`timescale 1ns/100ps
module tbp_teach_pd_monitor
  import tbp_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        rst_b_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic [31:0] distance_i,
  input wire logic        switching_channel_one_i,
  input wire logic        quality_low_i,
  input wire logic        alarm_i,
  input wire logic [7:0]  scale_i,
  input wire logic        pd_strobe_i,
  input wire tbp_pd_out_t pd_out_i,
  input wire tbp_pd_in_t  pd_in_o,
  input wire logic        laser_en_o,
  input wire logic [31:0] zero_pos_o,
  input wire logic [31:0] ana_lo_o,
  input wire logic [31:0] ana_hi_o,
  input wire logic        ana_invert_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  // Setup cycle of a register access
  wire setup = psel_i && !penable_i;

  // Register access answers; parameters only travel this way
  chk_zero_wait:
    assert property (pready_o == (psel_i && penable_i))
    else $error("ready does not follow the access phase");
  chk_unmapped_err:
    assert property (setup && paddr_i > REG_STATUS |=>
      pslverr_o && prdata_o == 32'h0)
    else $error("unmapped access not refused");
  chk_status_ro:
    assert property (setup && pwrite_i && paddr_i == REG_STATUS |=> pslverr_o)
    else $error("status write not refused");

  // Cyclic image fields follow the inputs seen at the strobe
  chk_pd_value:
    assert property (pd_strobe_i |=>
      pd_in_o.value == $past(distance_i) - $past(zero_pos_o))
    else $error("measured value field wrong");
  chk_pd_fields:
    assert property (pd_strobe_i |=> pd_in_o.scale == $past(scale_i) &&
      pd_in_o.alarm == $past(alarm_i) &&
      pd_in_o.quality_low == $past(quality_low_i) &&
      pd_in_o.switching_channel_one == $past(switching_channel_one_i))
    else $error("status or scale field wrong");
  chk_pd_spare:
    assert property (pd_in_o.rsvd_hi == 4'h0 && pd_in_o.rsvd_lo == 1'b0)
    else $error("spare input bits not zero");
  chk_laser_follow:
    assert property (pd_strobe_i |=> laser_en_o == $past(pd_out_i.laser_on))
    else $error("laser does not follow output bit");
  chk_hold_between:
    assert property (!pd_strobe_i |=> $stable(laser_en_o) && $stable(pd_in_o))
    else $error("image changed without a link cycle");
  chk_invert_slope:
    assert property (ana_invert_o ==
      ($signed($past(ana_lo_o)) > $signed($past(ana_hi_o))))
    else $error("inversion flag wrong");

  cov_laser: cover property (pd_strobe_i && pd_out_i.laser_on);
  cov_invert: cover property ($rose(ana_invert_o));
  cov_refused: cover property (setup ##1 pslverr_o);
endmodule : tbp_teach_pd_monitor

bind tbp_teach_pd tbp_teach_pd_monitor u_monitor (
  .mclk_i(mclk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .distance_i(distance_i), .quality_low_i(quality_low_i),
  .switching_channel_one_i(switching_channel_one_i),
  .alarm_i(alarm_i), .scale_i(scale_i), .pd_strobe_i(pd_strobe_i),
  .pd_out_i(pd_out_i), .pd_in_o(pd_in_o), .laser_en_o(laser_en_o),
  .zero_pos_o(zero_pos_o), .ana_lo_o(ana_lo_o), .ana_hi_o(ana_hi_o),
  .ana_invert_o(ana_invert_o));

// ===== bench/tbp_link_master.sv
// Link master model: cyclic strobe, output image, captured input image
`timescale 1ns/100ps
module tbp_link_master
  import tbp_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  input  wire logic       fast_i,
  input  wire logic       laser_req_i,
  input  wire logic       locate_req_i,
  input  wire tbp_pd_in_t pd_in_i,
  output logic            pd_strobe_o,
  output tbp_pd_out_t     pd_out_o,
  output tbp_pd_in_t      image_o
);
  logic [2:0] cyc;
  logic       strobe_d;

  // One exchange per link cycle, unasked; every cycle when fast
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cyc         <= 3'h0;
      pd_strobe_o <= 1'b0;
      strobe_d    <= 1'b0;
    end else begin
      cyc         <= (cyc == 3'h4) ? 3'h0 : cyc + 3'h1;
      pd_strobe_o <= fast_i || (cyc == 3'h4);
      strobe_d    <= pd_strobe_o;
    end
  end

  // Image is valid only at the strobe; inverted junk between strobes
  assign pd_out_o = pd_strobe_o ?
    tbp_pd_out_t'({6'h00, locate_req_i, laser_req_i}) :
    tbp_pd_out_t'({6'h3F, ~locate_req_i, ~laser_req_i});

  // Input image taken one cycle after the strobe, once it has landed
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      image_o <= '0;
    end else if (strobe_d) begin
      image_o <= pd_in_i;
    end
  end
endmodule : tbp_link_master

// ===== bench/test_teach_button_and_process_data.sv
// Self-checking bench for the teach button and process image block
`timescale 1ns/100ps
module test_teach_button_and_process_data import tbp_pkg::*;;
  localparam int TK = 4; // Short tick keeps every hold affordable
  logic        mclk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, distance_i = 32'h0;
  logic        button_i = 1'b0, sw_i = 1'b0, qlow_i = 1'b0, alarm_i = 1'b0;
  logic [7:0]  scale_i = 8'h00;
  logic        fast_i = 1'b0, laser_req = 1'b0, locate_req = 1'b0;
  logic [31:0] prdata_o, zero_pos_o, ana_lo_o, ana_hi_o, rdat;
  logic        pready_o, pslverr_o, pd_strobe_i, led_green_o, led_yellow_o;
  logic        laser_en_o, ana_invert_o, rerr, wsame, wyl;
  logic [1:0]  wg, wy;
  tbp_pd_out_t pd_out_i;
  tbp_pd_in_t  pd_in_o, image;
  int          n_errors = 0, tests_run = 0;

  tbp_teach_pd #(.TICK_CYC_P(TK)) dut (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .button_i(button_i), .distance_i(distance_i),
    .switching_channel_one_i(sw_i), .quality_low_i(qlow_i),
    .alarm_i(alarm_i), .scale_i(scale_i), .pd_strobe_i(pd_strobe_i),
    .pd_out_i(pd_out_i), .pd_in_o(pd_in_o), .led_green_o(led_green_o),
    .led_yellow_o(led_yellow_o), .laser_en_o(laser_en_o),
    .zero_pos_o(zero_pos_o), .ana_lo_o(ana_lo_o), .ana_hi_o(ana_hi_o),
    .ana_invert_o(ana_invert_o));

  tbp_link_master u_master (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .fast_i(fast_i), .laser_req_i(laser_req), .locate_req_i(locate_req),
    .pd_in_i(pd_in_o), .pd_strobe_o(pd_strobe_i), .pd_out_o(pd_out_i),
    .image_o(image));

  // 50 MHz clock
  always #10 mclk_i = ~mclk_i;

  task check(input logic [47:0] seen, input logic [47:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask : check

  task wt(input int n);
    repeat (n * TK) @(posedge mclk_i);
  endtask : wt

  task press(input int n);
    button_i <= 1'b1;
    wt(n);
    button_i <= 1'b0;
    wt(3);
  endtask : press

  // Counts indicator toggles over n ticks; one to seven toggles mean the slow rate
  task watch(input int n);
    int   tg, ty;
    logic pg, py;
    tg = 0;
    ty = 0;
    wsame = 1'b1;
    pg = led_green_o;
    py = led_yellow_o;
    repeat (n * TK) begin
      @(posedge mclk_i);
      tg += int'(led_green_o !== pg);
      ty += int'(led_yellow_o !== py);
      wsame &= (led_green_o === led_yellow_o);
      pg = led_green_o;
      py = led_yellow_o;
    end
    wg = (tg == 0) ? 2'h0 : (tg < 8) ? 2'h1 : 2'h2;
    wy = (ty == 0) ? 2'h0 : (ty < 8) ? 2'h1 : 2'h2;
    wyl = led_yellow_o;
  endtask : watch

  // Register access; an idle edge first so no signal is set twice
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 64);
    rdat = prdata_o;
    rerr = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rdat, exp);
  endtask : rd

  task t_regs;
    rd(REG_CTRL, 32'h0);
    rd(REG_TIMEOUT, 32'h0000_012C);
    rd(REG_ANA_HI, 32'h0000_FFFF);
    apb(1'b1, 12'h0FC, 32'h1);
    check(rerr, 1'b1);
    apb(1'b1, REG_STATUS, 32'h1);
    check(rerr, 1'b1);
    apb(1'b1, REG_ANA_LO, 32'h0000_0010);
    apb(1'b1, REG_ANA_HI, 32'h0000_0008);
    wt(1);
    check(ana_invert_o, 1'b1);
    apb(1'b1, REG_ANA_LO, 32'h0);
    apb(1'b1, REG_ANA_HI, 32'h0000_FFFF);
    $display("register test done");
  endtask : t_regs

  task t_pd;
    distance_i <= 32'h0000_1234;
    scale_i <= 8'hFA;
    {sw_i, qlow_i, alarm_i, laser_req, fast_i} <= 5'h1F;
    wt(4);
    check(image, {32'h0000_1234, 8'hFA, 8'h0D});
    check(laser_en_o, 1'b1);
    {sw_i, qlow_i, alarm_i, laser_req, fast_i} <= 5'h00;
    wt(4);
    check(image, {32'h0000_1234, 8'hFA, 8'h00});
    check(laser_en_o, 1'b0);
    locate_req <= 1'b1;
    wt(2);
    watch(16);
    check({wg, wy, wsame}, {2'h1, 2'h1, 1'b1});
    locate_req <= 1'b0;
    wt(2);
    $display("process data test done");
  endtask : t_pd

  task t_zero;
    distance_i <= 32'h0000_03E8;
    press(4);
    check({led_green_o, led_yellow_o}, 2'h3);
    button_i <= 1'b1;
    wt(34);
    watch(16);
    check({wg, wy, wsame, wyl}, {2'h1, 2'h0, 2'h0});
    button_i <= 1'b0;
    wt(3);
    press(4);
    check(zero_pos_o, 32'h0000_03E8);
    check({led_green_o, led_yellow_o}, 2'h3);
    distance_i <= 32'h0000_0384;
    wt(16);
    check({led_green_o, led_yellow_o}, 2'h2);
    check(image.value, 32'hFFFF_FF9C);
    $display("zero teach test done");
  endtask : t_zero

  task t_analog;
    distance_i <= 32'h0000_1388;
    press(4);
    button_i <= 1'b1;
    wt(66);
    watch(16);
    check({wg, wy, wsame}, {2'h0, 2'h1, 1'b0});
    button_i <= 1'b0;
    wt(3);
    press(4);
    check(ana_lo_o, 32'h0000_0FA0);
    distance_i <= 32'h0000_07D0;
    press(4);
    check(ana_hi_o, 32'h0000_03E8);
    check(ana_invert_o, 1'b1);
    wt(16);
    $display("analog teach test done");
  endtask : t_analog

  task t_fail_abandon;
    press(4);
    press(40);
    wt(962);
    watch(16);
    check({wg, wy, wsame}, {2'h2, 2'h2, 1'b1});
    check(zero_pos_o, 32'h0000_03E8);
    wt(40);
    press(4);
    button_i <= 1'b1;
    wt(200);
    check({led_green_o, led_yellow_o}, 2'h2);
    button_i <= 1'b0;
    wt(3);
    check({zero_pos_o, 16'h0}, {32'h0000_03E8, 16'h0});
    check(ana_lo_o, 32'h0000_0FA0);
    $display("failure and abandon test done");
  endtask : t_fail_abandon

  task t_factory;
    press(4);
    button_i <= 1'b1;
    wt(130);
    watch(16);
    check({wg, wy, wsame}, {2'h1, 2'h1, 1'b1});
    button_i <= 1'b0;
    wt(3);
    check(zero_pos_o, 32'h0000_0000);
    check(ana_hi_o, 32'h0000_FFFF);
    check({led_green_o, led_yellow_o}, 2'h3);
    wt(16);
    $display("factory reset test done");
  endtask : t_factory

  task t_mode_timeout;
    apb(1'b1, REG_CTRL, 32'h1);
    distance_i <= 32'h0000_04D2;
    press(40);
    press(4);
    check(zero_pos_o, 32'h0000_04D2);
    wt(16);
    apb(1'b1, REG_CTRL, 32'h0);
    apb(1'b1, REG_TIMEOUT, 32'h1);
    wt(20);
    repeat (2) press(4);
    check({led_green_o, led_yellow_o}, 2'h2);
    apb(1'b1, REG_CTRL, 32'h2);
    press(4);
    check({led_green_o, led_yellow_o}, 2'h3);
    apb(1'b1, REG_TIMEOUT, 32'h0000_012C);
    $display("mode and timeout test done");
  endtask : t_mode_timeout

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // Main sequence after two cycles of reset
  initial begin
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    t_regs();
    t_pd();
    t_zero();
    t_analog();
    t_fail_abandon();
    t_factory();
    t_mode_timeout();
    report_and_stop();
  end

  // Watchdog, about three and a half times the expected run
  initial begin
    repeat (25000) @(posedge mclk_i);
    n_errors++;
    report_and_stop();
  end
endmodule : test_teach_button_and_process_data
